// ### logic/hcsp_map.svh
// Register offsets, field positions, reset values and limits
`ifndef HCSP_MAP_SVH
`define HCSP_MAP_SVH
//==================================================================
// Byte offsets
`define HCSP_OFF_CTRL  8'h00
`define HCSP_OFF_SP    8'h04
`define HCSP_OFF_SPHI  8'h08
`define HCSP_OFF_SPLO  8'h0C
`define HCSP_OFF_DB    8'h10
`define HCSP_OFF_COEF  8'h14
`define HCSP_OFF_MRST  8'h18
`define HCSP_OFF_PB    8'h1C
`define HCSP_OFF_IT    8'h20
`define HCSP_OFF_DT    8'h24
`define HCSP_OFF_CPB   8'h28
`define HCSP_OFF_CIT   8'h2C
`define HCSP_OFF_CDT   8'h30
`define HCSP_OFF_ISP   8'h34
`define HCSP_OFF_MV    8'h38
`define HCSP_OFF_STAT  8'h3C
`define HCSP_OFF_CBAND 8'h40
//==================================================================
// Control word fields
`define HCSP_F_RUN   0
`define HCSP_F_ACT   1
`define HCSP_F_MODE  2
`define HCSP_F_CASG  3
`define HCSP_F_METH  4
//==================================================================
// Reset values (hexadecimal)
`define HCSP_SP_RST   16'sh0000
`define HCSP_SPHI_RST 16'sh270F
`define HCSP_SPLO_RST 16'shF831
`define HCSP_DB_RST   16'sh0000
`define HCSP_COEF_RST 16'h0064
`define HCSP_MRST_RST 11'h1F4
`define HCSP_PB_RST   16'sh0050
`define HCSP_IT_RST   16'h00E9
`define HCSP_DT_RST   16'h0190
//==================================================================
// Setting ranges: -1999, 9999, 0.01, 99.99, 100.0 %, 3999 s
`define HCSP_EU_MIN   16'shF831
`define HCSP_EU_MAX   16'sh270F
`define HCSP_COEF_MIN 16'h0001
`define HCSP_COEF_MAX 16'h270F
`define HCSP_COEF_ONE 32'h0000_0064
`define HCSP_PB_MIN   16'sh0001
`define HCSP_IT_MAX   16'h0F9F
`define HCSP_DT_MAX   16'h270F
`define HCSP_MV_FULL  11'h3E8
`endif

// ### logic/hcsp_pkg.sv
// Types shared by the set point conditioning block
`default_nettype none
package hcsp_pkg;
  typedef logic signed [15:0] hcsp_eu_t;
  typedef logic [10:0]        hcsp_mv_t;
  typedef enum logic {HCSP_REV = 1'b0, HCSP_DIR = 1'b1} hcsp_act_t;
  typedef enum logic {HCSP_STD = 1'b0, HCSP_HC = 1'b1} hcsp_mode_t;
  typedef enum logic [1:0] {
    HCSP_M_OFF   = 2'b00,
    HCSP_M_AIR   = 2'b01,
    HCSP_M_WATER = 2'b10,
    HCSP_M_LIN   = 2'b11
  } hcsp_meth_t;
  typedef struct packed {
    hcsp_eu_t    pb;
    logic [15:0] it;
    logic [15:0] dt;
  } hcsp_pid_t;
  typedef struct packed {
    logic       run;
    hcsp_act_t  act;
    hcsp_mode_t mode;
    logic       cool_asg;
    hcsp_meth_t meth;
  } hcsp_ctrl_t;
endpackage : hcsp_pkg
`default_nettype wire

// ### logic/hcsp_prop.sv
// Proportional term: error over band plus offset, clamped to 0..100.0 %
`default_nettype none
`include "hcsp_map.svh"
module hcsp_prop
  import hcsp_pkg::*;
#(
  parameter int ERR_W  = 18,
  parameter int BAND_W = 20
) (
  input  wire logic signed [ERR_W-1:0] err,
  input  wire logic [BAND_W-1:0]       band,
  input  wire hcsp_mv_t                offset,
  output var  hcsp_mv_t                mv
);
  localparam int P_W = ERR_W + BAND_W + 12;
  localparam logic signed [P_W-1:0] FULL = P_W'(`HCSP_MV_FULL);

  logic signed [P_W-1:0] err_x;
  logic signed [P_W-1:0] band_x;
  logic signed [P_W-1:0] sum;

  // Band is kept at one or more by the caller, so no divide by zero
  always_comb begin
    err_x  = P_W'(err);
    band_x = P_W'({1'b0, band});
    // Offset kept signed so a negative error is not read as unsigned
    sum    = (err_x * FULL) / band_x + $signed(P_W'({1'b0, offset}));
    if (sum < 0) begin
      mv = '0;
    end else if (sum > FULL) begin
      mv = `HCSP_MV_FULL;
    end else begin
      mv = sum[10:0];
    end
  end
endmodule : hcsp_prop
`default_nettype wire

// ### logic/hcsp_top.sv
// Heating/cooling action and set point conditioning, AXI4-Lite slave
//==================================================================
`default_nettype none
`include "hcsp_map.svh"
module hcsp_top
  import hcsp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              sample_tick,
  input  wire hcsp_eu_t          process_value,
  input  wire hcsp_eu_t          in_range_lo,
  input  wire hcsp_eu_t          in_range_hi,
  input  wire logic [1:0]        sens_dec_pos,
  input  wire logic              auto_tuning_done,
  input  wire hcsp_pid_t         auto_tuning_heat,
  input  wire hcsp_pid_t         auto_tuning_cool,
  output var  hcsp_eu_t          isp_q,
  output var  hcsp_mv_t          heat_mv_q,
  output var  hcsp_mv_t          cool_mv_q,
  output var  logic              hc_q,
  output var  logic [19:0]       cool_band_q,
  output var  logic [1:0]        cool_dec_pos_q,
  output var  hcsp_pid_t         heat_pid_q,
  output var  hcsp_pid_t         cool_pid_q
);
  //==================================================================
  // Declarations
  hcsp_ctrl_t        ctrl_q;
  hcsp_eu_t          sp_q;
  hcsp_eu_t          sp_hi_q;
  hcsp_eu_t          sp_lo_q;
  hcsp_eu_t          db_q;
  logic [15:0]       coef_q;
  hcsp_mv_t          mrst_q;
  hcsp_pid_t         hpid_q;
  hcsp_pid_t         cpid_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0]       wr_data_q;
  logic [3:0]        wr_strb_q;
  logic [32:0]       wr_cur;
  logic [32:0]       rd_cur;
  logic [31:0]       wr_new;
  hcsp_eu_t          wv_s;
  logic              wr_go;
  logic              wr_ok;
  hcsp_eu_t          lim_hi;
  hcsp_eu_t          lim_lo;
  hcsp_eu_t          eff_hi;
  hcsp_eu_t          eff_lo;
  hcsp_eu_t          isp_d;
  hcsp_eu_t          half;
  logic              hc;
  logic signed [17:0] std_err;
  logic signed [17:0] heat_err;
  logic signed [17:0] cool_err;
  logic signed [17:0] h_err;
  logic [31:0]       cprod;
  logic [19:0]       cband_x;
  logic [19:0]       cband;
  hcsp_mv_t          std_off;
  hcsp_mv_t          h_off;
  hcsp_mv_t          h_mv;
  hcsp_mv_t          c_mv;

  //==================================================================
  // Register read mux; bit 32 flags a mapped offset
  function automatic logic [32:0] reg_rd(input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (a)
      `HCSP_OFF_CTRL: begin
        r[`HCSP_F_RUN]       = ctrl_q.run;
        r[`HCSP_F_ACT]       = ctrl_q.act;
        r[`HCSP_F_MODE]      = ctrl_q.mode;
        r[`HCSP_F_CASG]      = ctrl_q.cool_asg;
        r[`HCSP_F_METH +: 2] = ctrl_q.meth;
      end
      `HCSP_OFF_SP:    r[15:0] = sp_q;
      `HCSP_OFF_SPHI:  r[15:0] = sp_hi_q;
      `HCSP_OFF_SPLO:  r[15:0] = sp_lo_q;
      `HCSP_OFF_DB:    r[15:0] = db_q;
      `HCSP_OFF_COEF:  r[15:0] = coef_q;
      `HCSP_OFF_MRST:  r[10:0] = mrst_q;
      `HCSP_OFF_PB:    r[15:0] = hpid_q.pb;
      `HCSP_OFF_IT:    r[15:0] = hpid_q.it;
      `HCSP_OFF_DT:    r[15:0] = hpid_q.dt;
      `HCSP_OFF_CPB:   r[15:0] = cpid_q.pb;
      `HCSP_OFF_CIT:   r[15:0] = cpid_q.it;
      `HCSP_OFF_CDT:   r[15:0] = cpid_q.dt;
      `HCSP_OFF_ISP:   r[15:0] = isp_q;
      `HCSP_OFF_MV:    r[26:0] = {cool_mv_q, 5'h00, heat_mv_q};
      `HCSP_OFF_STAT:  r[2:0]  = {hc_q, cool_dec_pos_q};
      `HCSP_OFF_CBAND: r[19:0] = cool_band_q;
      default:         r[32]   = 1'b0;
    endcase
    return r;
  endfunction : reg_rd

  function automatic logic in_eu(input hcsp_eu_t v, input hcsp_eu_t lo,
                                 input hcsp_eu_t hi);
    return (v >= lo) && (v <= hi);
  endfunction : in_eu

  //==================================================================
  // Write decode and range check; out-of-range values are refused
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_comb begin
    wr_cur = reg_rd(wr_addr_q);
    rd_cur = reg_rd(s_axi_araddr);
    for (int i = 0; i < 4; i++) begin
      wr_new[8*i +: 8] = wr_strb_q[i] ? wr_data_q[8*i +: 8]
                                      : wr_cur[8*i +: 8];
    end
    wv_s = wr_new[15:0];
    case (wr_addr_q)
      `HCSP_OFF_CTRL: wr_ok = 1'b1;
      `HCSP_OFF_SP,
      `HCSP_OFF_SPHI,
      `HCSP_OFF_SPLO,
      `HCSP_OFF_DB:   wr_ok = in_eu(wv_s, `HCSP_EU_MIN, `HCSP_EU_MAX);
      `HCSP_OFF_COEF: wr_ok = (wr_new[15:0] >= `HCSP_COEF_MIN) &&
                              (wr_new[15:0] <= `HCSP_COEF_MAX);
      `HCSP_OFF_MRST: wr_ok = wr_new[15:0] <= 16'(`HCSP_MV_FULL);
      `HCSP_OFF_PB,
      `HCSP_OFF_CPB:  wr_ok = in_eu(wv_s, `HCSP_PB_MIN, `HCSP_EU_MAX);
      `HCSP_OFF_IT,
      `HCSP_OFF_CIT:  wr_ok = wr_new[15:0] <= `HCSP_IT_MAX;
      `HCSP_OFF_DT,
      `HCSP_OFF_CDT:  wr_ok = wr_new[15:0] <= `HCSP_DT_MAX;
      default:        wr_ok = 1'b0;
    endcase
  end

  //==================================================================
  // AXI4-Lite write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      wr_addr_q     <= '0;
      wr_data_q     <= 32'h0000_0000;
      wr_strb_q     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data_q    <= s_axi_wdata;
        wr_strb_q    <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  //==================================================================
  // AXI4-Lite read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_cur[31:0];
      s_axi_rresp   <= rd_cur[32] ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //==================================================================
  // Control word; mode fields judged against the run state before write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '{run: 1'b0, act: HCSP_REV, mode: HCSP_STD,
                 cool_asg: 1'b0, meth: HCSP_M_OFF};
    end else if (wr_go && wr_ok && wr_addr_q == `HCSP_OFF_CTRL) begin
      ctrl_q.run      <= wr_new[`HCSP_F_RUN];
      ctrl_q.cool_asg <= wr_new[`HCSP_F_CASG];
      ctrl_q.meth     <= hcsp_meth_t'(wr_new[`HCSP_F_METH +: 2]);
      if (!ctrl_q.run) begin
        ctrl_q.act  <= hcsp_act_t'(wr_new[`HCSP_F_ACT]);
        ctrl_q.mode <= hcsp_mode_t'(wr_new[`HCSP_F_MODE]);
      end
    end
  end

  //==================================================================
  // Set point and limiter settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q    <= `HCSP_SP_RST;
      sp_hi_q <= `HCSP_SPHI_RST;
      sp_lo_q <= `HCSP_SPLO_RST;
    end else if (wr_go && wr_ok) begin
      case (wr_addr_q)
        `HCSP_OFF_SP:   sp_q    <= wv_s;
        `HCSP_OFF_SPHI: sp_hi_q <= wv_s;
        `HCSP_OFF_SPLO: sp_lo_q <= wv_s;
        default: ;
      endcase
    end
  end

  //==================================================================
  // Heating/cooling shaping and manual reset settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      db_q   <= `HCSP_DB_RST;
      coef_q <= `HCSP_COEF_RST;
      mrst_q <= `HCSP_MRST_RST;
    end else if (wr_go && wr_ok) begin
      case (wr_addr_q)
        `HCSP_OFF_DB:   db_q   <= wv_s;
        `HCSP_OFF_COEF: coef_q <= wr_new[15:0];
        `HCSP_OFF_MRST: mrst_q <= wr_new[10:0];
        default: ;
      endcase
    end
  end

  //==================================================================
  // PID constants; a tuning result wins over a host write that cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hpid_q <= '{pb: `HCSP_PB_RST, it: `HCSP_IT_RST, dt: `HCSP_DT_RST};
      cpid_q <= '{pb: `HCSP_PB_RST, it: `HCSP_IT_RST,
                  dt: `HCSP_DT_RST};
    end else if (auto_tuning_done) begin
      hpid_q <= auto_tuning_heat;
      if (ctrl_q.meth != HCSP_M_OFF) begin
        cpid_q <= auto_tuning_cool;
      end
    end else if (wr_go && wr_ok) begin
      case (wr_addr_q)
        `HCSP_OFF_PB:  hpid_q.pb <= wv_s;
        `HCSP_OFF_IT:  hpid_q.it <= wr_new[15:0];
        `HCSP_OFF_DT:  hpid_q.dt <= wr_new[15:0];
        `HCSP_OFF_CPB: cpid_q.pb <= wv_s;
        `HCSP_OFF_CIT: cpid_q.it <= wr_new[15:0];
        `HCSP_OFF_CDT: cpid_q.dt <= wr_new[15:0];
        default: ;
      endcase
    end
  end

  //==================================================================
  // Internal set point and action shaping
  always_comb begin
    lim_hi = (sp_lo_q > sp_hi_q) ? sp_lo_q : sp_hi_q;
    lim_lo = (sp_lo_q > sp_hi_q) ? sp_hi_q : sp_lo_q;
    eff_hi = (lim_hi > in_range_hi) ? in_range_hi : lim_hi;
    eff_lo = (lim_lo < in_range_lo) ? in_range_lo : lim_lo;
    // Only the copy is clamped; the stored value stays as written
    if (sp_q > eff_hi) begin
      isp_d = eff_hi;
    end else if (sp_q < eff_lo) begin
      isp_d = eff_lo;
    end else begin
      isp_d = sp_q;
    end
    hc   = (ctrl_q.mode == HCSP_HC) && ctrl_q.cool_asg;
    half = db_q >>> 1;
    if (ctrl_q.act == HCSP_DIR) begin
      std_err = 18'(process_value) - 18'(isp_d);
    end else begin
      std_err = 18'(isp_d) - 18'(process_value);
    end
    // Negative half widens both errors, so the outputs overlap
    heat_err = 18'(isp_d) - 18'(half) - 18'(process_value);
    cool_err = 18'(process_value) - 18'(isp_d) - 18'(half);
    cprod    = 32'($unsigned(hpid_q.pb)) * 32'(coef_q);
    cband_x  = 20'(cprod / `HCSP_COEF_ONE);
    if (ctrl_q.meth != HCSP_M_OFF) begin
      cband = 20'($unsigned(cpid_q.pb));
    end else begin
      cband = (cband_x == 20'h00000) ? 20'h00001 : cband_x;
    end
    std_off = (hpid_q.it == 16'h0000) ? mrst_q : 11'h000;
    h_err   = hc ? heat_err : std_err;
    h_off   = hc ? 11'h000 : std_off;
  end

  hcsp_prop #(.ERR_W(18), .BAND_W(20)) u_heat (
    .err    (h_err),
    .band   (20'($unsigned(hpid_q.pb))),
    .offset (h_off),
    .mv     (h_mv)
  );

  hcsp_prop #(.ERR_W(18), .BAND_W(20)) u_cool (
    .err    (cool_err),
    .band   (cband),
    .offset (11'h000),
    .mv     (c_mv)
  );

  //==================================================================
  // Sampled results, refreshed on each control sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isp_q       <= `HCSP_SP_RST;
      heat_mv_q   <= 11'h000;
      cool_mv_q   <= 11'h000;
      hc_q        <= 1'b0;
      cool_band_q <= 20'h00000;
    end else if (sample_tick) begin
      isp_q       <= isp_d;
      heat_mv_q   <= h_mv;
      cool_mv_q   <= hc ? c_mv : 11'h000;
      hc_q        <= hc;
      cool_band_q <= cband;
    end
  end

  // Constants handed to the external PID law every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      heat_pid_q     <= '0;
      cool_pid_q     <= '0;
      cool_dec_pos_q <= 2'h1;
    end else begin
      heat_pid_q     <= hpid_q;
      cool_pid_q     <= (ctrl_q.meth != HCSP_M_OFF) ? cpid_q : hpid_q;
      cool_dec_pos_q <= (sens_dec_pos == 2'h0) ? 2'h1
                                               : sens_dec_pos;
    end
  end

  //==================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ctrl_wr_run;
    wr_go && wr_ok && (wr_addr_q == `HCSP_OFF_CTRL) && ctrl_q.run;
  endsequence

  sequence s_tick_std;
    sample_tick && !hc;
  endsequence

  a_act_locked_run: assert property (
    s_ctrl_wr_run |=> ctrl_q.act == $past(ctrl_q.act))
    else $error("polarity changed while running");
  a_mode_locked_run: assert property (
    s_ctrl_wr_run |=> ctrl_q.mode == $past(ctrl_q.mode))
    else $error("output mode changed while running");
  a_sp_in_range: assert property (
    sp_q >= `HCSP_EU_MIN && sp_q <= `HCSP_EU_MAX)
    else $error("stored set point out of range");
  a_coef_in_range: assert property (
    coef_q >= `HCSP_COEF_MIN && coef_q <= `HCSP_COEF_MAX)
    else $error("cooling coefficient out of range");
  a_isp_clamped: assert property (
    sample_tick && eff_lo <= eff_hi |=>
      isp_q <= $past(eff_hi) && isp_q >= $past(eff_lo))
    else $error("internal set point outside limits");
  a_isp_passes_sp: assert property (
    sample_tick && !wr_go && sp_q >= eff_lo && sp_q <= eff_hi |=>
      isp_q == $past(sp_q) && sp_q == $past(sp_q))
    else $error("in-range set point not used as is");
  a_limit_swap_used: assert property (
    sample_tick && sp_lo_q > sp_hi_q && sp_q > sp_lo_q &&
      sp_lo_q <= in_range_hi |=> isp_q == $past(sp_lo_q))
    else $error("swapped lower limit not used as upper");
  a_std_cool_off: assert property (
    s_tick_std |=> cool_mv_q == 11'h000)
    else $error("cooling output active outside heating/cooling");
  a_dead_zone_off: assert property (
    sample_tick && hc && db_q >= 0 &&
      process_value >= isp_d - half && process_value <= isp_d + half
      |=> heat_mv_q == 11'h000 && cool_mv_q == 11'h000)
    else $error("output active inside dead band");
  a_mreset_offset: assert property (
    (s_tick_std and (process_value == isp_d)) |=>
      heat_mv_q == $past(std_off))
    else $error("manual reset offset not applied");
  a_action_sense: assert property (
    (s_tick_std and (process_value > isp_d)) |=>
      ($past(ctrl_q.act) == HCSP_DIR) ? heat_mv_q >= $past(std_off)
                               : heat_mv_q <= $past(std_off))
    else $error("action polarity wrong");
  a_tune_cool_store: assert property (
    auto_tuning_done && ctrl_q.meth != HCSP_M_OFF |=>
      cpid_q == $past(auto_tuning_cool))
    else $error("cooling constants not stored by tuning");
  a_cool_dp_nonzero: assert property (
    ##1 cool_dec_pos_q != 2'h0)
    else $error("cooling decimal position is zero");
endmodule : hcsp_top
`default_nettype wire

// ### verif/hcsp_top_tb_top.sv
// Self-checking bench for the set point conditioning block
`default_nettype none
`include "hcsp_map.svh"
module hcsp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, sample_tick, auto_tuning_done, hc_q;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, sens_dec_pos, cool_dec_pos_q;
  logic signed [15:0] process_value, in_range_lo, in_range_hi, isp_q;
  logic [10:0] heat_mv_q, cool_mv_q;
  logic [19:0] cool_band_q;
  logic [47:0] auto_tuning_heat, auto_tuning_cool;
  logic [47:0] heat_pid_q, cool_pid_q;
  int failures, checked;
  hcsp_top u_hcsp_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sample_tick, .process_value, .in_range_lo,
    .in_range_hi, .sens_dec_pos, .auto_tuning_done, .auto_tuning_heat,
    .auto_tuning_cool, .isp_q, .heat_mv_q, .cool_mv_q, .hc_q,
    .cool_band_q, .cool_dec_pos_q, .heat_pid_q, .cool_pid_q);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  //================================================================
  // Shared tasks
  task automatic results;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hang(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t no answer", $time);
      results();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    hang(s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    hang(s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : rd
  // Outputs land at the tick edge; look one edge later
  task automatic tick(input logic signed [15:0] pv);
    process_value <= pv;
    sample_tick <= 1'b1;
    @(posedge aclk);
    sample_tick <= 1'b0;
    @(posedge aclk);
  endtask : tick
  //================================================================
  // Scenarios
  task automatic t_reset;
    rd(`HCSP_OFF_CTRL, 32'h0, 2'h0);
    rd(`HCSP_OFF_SP, 32'h0, 2'h0);
    rd(`HCSP_OFF_SPHI, 32'h270F, 2'h0);
    rd(`HCSP_OFF_SPLO, 32'hF831, 2'h0);
    rd(`HCSP_OFF_COEF, 32'h64, 2'h0);
    rd(`HCSP_OFF_DB, 32'h0, 2'h0);
    rd(`HCSP_OFF_MRST, 32'h1F4, 2'h0);
    rd(`HCSP_OFF_CIT, 32'hE9, 2'h0);
    rd(`HCSP_OFF_CDT, 32'h190, 2'h0);
    rd(8'h44, 32'h0, 2'h2);
    wr(`HCSP_OFF_COEF, 32'h0, 2'h2);
    wr(`HCSP_OFF_COEF, 32'h2710, 2'h2);
    wr(`HCSP_OFF_SP, 32'h2710, 2'h2);
    wr(`HCSP_OFF_DB, 32'hF830, 2'h2);
    $display("test reset and ranges done");
  endtask : t_reset
  task automatic t_action;
    wr(`HCSP_OFF_CTRL, 32'h1, 2'h0);
    wr(`HCSP_OFF_CTRL, 32'h7, 2'h0);
    rd(`HCSP_OFF_CTRL, 32'h1, 2'h0);
    wr(`HCSP_OFF_CTRL, 32'h6, 2'h0);
    rd(`HCSP_OFF_CTRL, 32'h0, 2'h0);
    wr(`HCSP_OFF_CTRL, 32'h2, 2'h0);
    tick(16'sd40);
    chk({21'h0, heat_mv_q}, 32'h1F4);
    wr(`HCSP_OFF_CTRL, 32'h0, 2'h0);
    tick(16'sd40);
    chk({21'h0, heat_mv_q}, 32'h0);
    wr(`HCSP_OFF_IT, 32'h0, 2'h0);
    tick(16'sd0);
    chk({21'h0, heat_mv_q}, 32'h1F4);
    $display("test action done");
  endtask : t_action
  task automatic t_clamp;
    in_range_hi <= 16'sd500;
    wr(`HCSP_OFF_SP, 32'h320, 2'h0);
    wr(`HCSP_OFF_SPHI, 32'h12C, 2'h0);
    wr(`HCSP_OFF_SPLO, 32'h258, 2'h0);
    tick(16'sd0);
    chk({16'h0, isp_q}, 32'h1F4);
    rd(`HCSP_OFF_SP, 32'h320, 2'h0);
    wr(`HCSP_OFF_SP, 32'hFF38, 2'h0);
    tick(16'sd0);
    chk({16'h0, isp_q}, 32'h12C);
    in_range_hi <= 16'sd9999;
    wr(`HCSP_OFF_SP, 32'h320, 2'h0);
    tick(16'sd0);
    chk({16'h0, isp_q}, 32'h258);
    // Back to wide limits so later scenarios see the set point as is
    wr(`HCSP_OFF_SPHI, 32'h270F, 2'h0);
    wr(`HCSP_OFF_SPLO, 32'hF831, 2'h0);
    wr(`HCSP_OFF_SP, 32'h0, 2'h0);
    $display("test clamp done");
  endtask : t_clamp
  task automatic t_hc;
    wr(`HCSP_OFF_COEF, 32'hFA, 2'h0);
    wr(`HCSP_OFF_CTRL, 32'h4, 2'h0);
    tick(16'sd0);
    chk({31'h0, hc_q}, 32'h0);
    wr(`HCSP_OFF_CTRL, 32'hC, 2'h0);
    wr(`HCSP_OFF_DB, 32'hFFEC, 2'h0);
    tick(16'sd0);
    chk({31'h0, hc_q}, 32'h1);
    chk({12'h0, cool_band_q}, 32'hC8);
    chk({30'h0, cool_dec_pos_q}, 32'h1);
    chk({21'h0, heat_mv_q}, 32'h7D);
    chk({21'h0, cool_mv_q}, 32'h32);
    wr(`HCSP_OFF_DB, 32'h28, 2'h0);
    tick(16'sd30);
    chk({21'h0, heat_mv_q}, 32'h0);
    chk({21'h0, cool_mv_q}, 32'h32);
    tick(16'sd10);
    chk({21'h0, heat_mv_q}, 32'h0);
    chk({21'h0, cool_mv_q}, 32'h0);
    for (int m = 1; m < 4; m++) begin
      wr(`HCSP_OFF_CTRL, 32'hC | (m << 4), 2'h0);
      tick(16'sd0);
      chk({12'h0, cool_band_q}, 32'h50);
    end
    auto_tuning_cool <= {16'h0078, 16'h0064, 16'h0032};
    auto_tuning_done <= 1'b1;
    @(posedge aclk);
    auto_tuning_done <= 1'b0;
    rd(`HCSP_OFF_CPB, 32'h78, 2'h0);
    chk({16'h0, cool_pid_q[47:32]}, 32'h78);
    chk(cool_pid_q[31:0], 32'h0064_0032);
    chk(heat_pid_q[31:0], 32'h00E9_0190);
    $display("test heating cooling done");
  endtask : t_hc
  //================================================================
  // Main sequence
  initial begin
    {aresetn, sample_tick, auto_tuning_done} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot, sens_dec_pos} = 8'h0;
    s_axi_wstrb = 4'hF;
    {process_value, in_range_lo} = {16'sh0000, -16'sd100};
    in_range_hi = 16'sd9999;
    {auto_tuning_heat, auto_tuning_cool} = {48'h0050_00E9_0190, 48'h0};
    {failures, checked} = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_action();
    t_clamp();
    t_hc();
    results();
  end
endmodule : hcsp_top_tb_top
`default_nettype wire
